// ==== hdl/ctx_pkg.sv ====
// Constants for the MACsec transform record interpreter.
// Assumes a single 200 MHz clock domain and a 32-bit APB register bus.
package ctx_pkg;
  // Record geometry.
  localparam int unsigned REC_WORDS_MAX  = 24;            // Largest record, in words.
  localparam int unsigned REC_WORDS_SMALL = 20;           // Record size when the small size is selected.
  localparam int unsigned SA_COUNT       = 4;             // Default number of SA records.
  localparam int unsigned IDX_W          = 5;             // Bits that index a word within a record.

  // Word positions inside a record.
  localparam logic [4:0] W_CTRL  = 5'h00;                 // Control word.
  localparam logic [4:0] W_KEY0  = 5'h02;                 // First cipher key word.
  localparam logic [4:0] W_HK128 = 5'h06;                 // First hash key word, 128-bit keys.
  localparam logic [4:0] W_HK256 = 5'h0a;                 // First hash key word, 256-bit keys.
  localparam logic [4:0] W_SEQ128 = 5'h0a;                // Sequence word, 128-bit keys.
  localparam logic [4:0] W_SEQ256 = 5'h0e;                // Sequence word, 256-bit keys.

  // Control word field positions.
  localparam int unsigned F_TOP_LSB   = 0;                // Packet type, 4 bits.
  localparam int unsigned F_UPD_SEQ   = 13;               // Sequence update enable.
  localparam int unsigned F_CIPH_LSB  = 17;               // Cipher select, 3 bits.
  localparam int unsigned F_AN_LSB    = 26;               // Association number, 2 bits.
  localparam int unsigned F_STYP_LSB  = 28;               // Sequence type, 2 bits.

  // Control word encodings.
  localparam logic [3:0] TOP_EGRESS  = 4'h6;              // Egress packet type.
  localparam logic [3:0] TOP_INGRESS = 4'hf;              // Ingress packet type.
  localparam logic [2:0] CIPH_AES128 = 3'h5;              // AES counter mode, 128-bit key.
  localparam logic [2:0] CIPH_AES256 = 3'h7;              // AES counter mode, 256-bit key.
  localparam logic [1:0] STYP_SEQ32  = 2'h1;              // 32-bit sequence number.
  localparam logic [31:0] SEQ_MAX    = 32'hffffffff;      // Last sequence value before wrap.

  // APB register map (byte addresses).
  localparam logic [11:0] A_CONFIG  = 12'h000;            // Context size select, bit 0 only.
  localparam logic [11:0] A_STATUS  = 12'h004;            // Last check result.
  localparam logic [11:0] A_RECORD  = 12'h400;            // Base of the record array window.
  localparam logic [31:0] CONFIG_RST = 32'h00000000;      // Reset value of the configuration register.

  // Flow kinds presented with each request.
  typedef enum logic [1:0] {
    FLOW_MACSEC = 2'b00,
    FLOW_BYPASS = 2'b01,
    FLOW_DROP   = 2'b10
  } flow_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CTRL  = 3'b001,
    ST_FETCH = 3'b010,
    ST_CHECK = 3'b011,
    ST_WBACK = 3'b100,
    ST_DONE  = 3'b101
  } state_t;
endpackage : ctx_pkg

// ==== hdl/ctx_ram.sv ====
// Simple two-port word memory that holds all transform records.
// Assumes one clock; port A belongs to software, port B to the sequencer.
`timescale 1ns/1ps
module ctx_ram #(
  parameter int unsigned DEPTH = 96,
  parameter int unsigned AW    = 7
) (
  input  wire logic          clk_sys,
  input  wire logic          a_we,
  input  wire logic [AW-1:0] a_addr,
  input  wire logic [31:0]   a_wdata,
  output logic      [31:0]   a_rdata,
  input  wire logic          b_we,
  input  wire logic [AW-1:0] b_addr,
  input  wire logic [31:0]   b_wdata,
  output logic      [31:0]   b_rdata
);
  // Storage array; contents are undefined until software writes them.
  logic [31:0] mem [DEPTH];

  // Both ports share one process so the array has a single driver.
  // Port B wins a same-word clash, but software must not write the record under work anyway.
  always_ff @(posedge clk_sys) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end
endmodule : ctx_ram

// ==== hdl/ctx_seq_check.sv ====
// Transform record interpreter: decodes the control word, loads keys and runs the sequence check.
// Assumes APB from software and a one-request-at-a-time packet interface from the transform stage.
`timescale 1ns/1ps
module ctx_seq_check
  import ctx_pkg::*;
#(
  parameter int unsigned NUM_SA = ctx_pkg::SA_COUNT
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  // APB slave.
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Packet request from the transform stage.
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire ctx_pkg::flow_t       req_flow,
  input  wire logic [1:0]           req_sa,
  input  wire logic [31:0]          req_pn,
  // Result towards the transform stage.
  output logic                      res_valid,
  output logic                      res_pass,
  output logic                      res_is_egress,
  output logic [31:0]               res_pn,
  output logic [1:0]                res_an,
  output logic                      res_aes256,
  output logic [255:0]              res_key,
  output logic [127:0]              res_hash_key,
  output logic                      seq_error,
  output logic                      replay_fail_error_flag,
  output logic                      ctx_invalid
);
  localparam int unsigned DEPTH = NUM_SA * REC_WORDS_MAX;
  localparam int unsigned AW    = $clog2(DEPTH);

  // Configuration: bit 0 selects the small record size.
  logic [31:0] config_r;
  // Status: copy of the last result flags.
  logic [2:0]  status_r;

  state_t      state_r;                        // Sequencer state.
  logic [4:0]  widx_r;                         // Word being fetched.
  logic [4:0]  wlast_r;                        // Last word of this fetch.
  logic [1:0]  sa_r;                           // SA under work.
  logic [31:0] pn_r;                           // Received packet number.
  logic [31:0] ctrl_r;                         // Latched control word.
  logic [31:0] seq_r;                          // Stored sequence value.
  logic [31:0] mask_r;                         // Stored replay window.
  logic [31:0] seq_new_r;                      // Value to write back.
  logic        do_wb_r;                        // Write back wanted.
  logic        fetch_pend_r;                   // Read data valid in b_rdata this cycle.
  logic [4:0]  fetch_idx_r;                    // Word index of that read data.

  // Memory ports.
  logic          a_we;
  logic [AW-1:0] a_addr;
  logic [31:0]   a_rdata;
  logic          b_we;
  logic [AW-1:0] b_addr;
  logic [31:0]   b_rdata;

  // Decoded control word fields; reserved bits are never looked at.
  logic [3:0] top;
  logic [2:0] ciph;
  logic       is_eg;
  logic       is_ig;
  logic       big_key;
  logic [4:0] seq_word;
  logic       upd_seq;
  assign top      = ctrl_r[F_TOP_LSB +: 4];
  assign is_eg    = (top == TOP_EGRESS);
  assign is_ig    = (top == TOP_INGRESS);
  assign ciph     = ctrl_r[F_CIPH_LSB +: 3];
  assign big_key  = (ciph == CIPH_AES256);
  assign seq_word = big_key ? W_SEQ256 : W_SEQ128;
  assign upd_seq  = ctrl_r[F_UPD_SEQ];

  // Validity of the fields that steer hardware.
  logic ctrl_ok;
  assign ctrl_ok = (is_eg || is_ig) && (ciph == CIPH_AES128 || ciph == CIPH_AES256)
                   && (ctrl_r[F_STYP_LSB +: 2] == STYP_SEQ32);

  // Ingress comparison, all unsigned 32-bit.
  logic        ig_fresh;
  logic        ig_window;
  logic [32:0] ig_dist;
  assign ig_fresh  = (pn_r >= seq_r);
  assign ig_dist   = {1'b0, seq_r} - {1'b0, pn_r};
  assign ig_window = (ig_dist[31:0] <= mask_r);

  // APB decode; writes take effect and reads are answered at the same edge, one cycle into the access, when pready is high.
  logic acc;
  logic in_rec;
  logic [11:0] roff;
  assign acc    = psel && penable;
  assign in_rec = (paddr >= A_RECORD) && (paddr < A_RECORD + 12'(DEPTH * 4));
  assign roff   = paddr - A_RECORD;
  assign a_we   = acc && pready && pwrite && in_rec;
  assign a_addr = AW'(roff[11:2]);

  // A record read needs the registered memory output, so every access waits one cycle.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  // Read data and error answer; unmapped addresses read zero and raise pslverr.
  always_comb begin
    prdata  = 32'h00000000;
    pslverr = 1'b0;
    if (in_rec) begin
      prdata = a_rdata;
    end else if (paddr == A_CONFIG) begin
      prdata = config_r;
    end else if (paddr == A_STATUS) begin
      prdata = {29'h0, status_r};
    end else begin
      pslverr = acc && pready;
    end
  end

  // Configuration register write.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      config_r <= CONFIG_RST;
    end else if (acc && pready && pwrite && paddr == A_CONFIG) begin
      config_r <= {31'h0, pwdata[0]};
    end
  end

  // Main sequencer.
  assign req_ready = (state_r == ST_IDLE);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r <= ST_IDLE;
      sa_r    <= 2'h0;
      pn_r    <= 32'h0;
      widx_r  <= 5'h0;
      wlast_r <= 5'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (req_valid) begin
            sa_r <= req_sa;
            pn_r <= req_pn;
            widx_r <= W_CTRL;
            // Bypass and drop flows answer at once without touching memory.
            state_r <= (req_flow == FLOW_MACSEC) ? ST_CTRL : ST_DONE;
          end
        end
        ST_CTRL: begin
          // Control word arrives one cycle after its read.
          if (fetch_pend_r && fetch_idx_r == W_CTRL) begin
            widx_r  <= 5'h1;
            wlast_r <= config_r[0] ? 5'(REC_WORDS_SMALL - 1) : 5'(REC_WORDS_MAX - 1);
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (widx_r == wlast_r) begin
            state_r <= ST_CHECK;
          end else begin
            widx_r <= widx_r + 5'h1;
          end
        end
        ST_CHECK: begin
          // The decision lands at this same edge, so the write-back cycle itself tests it.
          if (!fetch_pend_r) begin
            state_r <= ST_WBACK;
          end
        end
        ST_WBACK: state_r <= ST_DONE;
        ST_DONE:  state_r <= ST_IDLE;
        default:  state_r <= ST_IDLE;
      endcase
    end
  end

  // Port B address and write; only the sequence word is ever written.
  assign b_addr  = AW'(sa_r * REC_WORDS_MAX + ((state_r == ST_WBACK) ? seq_word : widx_r));
  assign b_we    = (state_r == ST_WBACK) && do_wb_r;
  wire   rd_now  = (state_r == ST_CTRL && !fetch_pend_r) || (state_r == ST_FETCH);

  // Track read data returning from the memory.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fetch_pend_r <= 1'b0;
      fetch_idx_r  <= 5'h0;
    end else begin
      fetch_pend_r <= rd_now && !(state_r == ST_CTRL && fetch_pend_r);
      fetch_idx_r  <= widx_r;
    end
  end

  // Capture of fetched words into key, hash key, sequence and window holders.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_r       <= 32'h0;
      seq_r        <= 32'h0;
      mask_r       <= 32'h0;
      res_key      <= 256'h0;
      res_hash_key <= 128'h0;
    end else if (fetch_pend_r) begin
      if (fetch_idx_r == W_CTRL) begin
        ctrl_r  <= b_rdata;
        res_key <= 256'h0;
        mask_r  <= 32'h0;
      end else if (fetch_idx_r >= W_KEY0 && fetch_idx_r < W_KEY0 + (big_key ? 5'h8 : 5'h4)) begin
        // Word n lands in bits 32n upward; bytes inside stay little endian.
        res_key[32*(fetch_idx_r - W_KEY0) +: 32] <= b_rdata;
      end else if (fetch_idx_r >= (big_key ? W_HK256 : W_HK128) && fetch_idx_r < seq_word) begin
        res_hash_key[32*(fetch_idx_r - (big_key ? W_HK256 : W_HK128)) +: 32] <= b_rdata;
      end else if (fetch_idx_r == seq_word) begin
        seq_r <= b_rdata;
      end else if (fetch_idx_r == seq_word + 5'h2 && is_ig) begin
        mask_r <= b_rdata;
      end
    end
  end

  // Decision made once the whole record is in.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      do_wb_r                <= 1'b0;
      seq_new_r              <= 32'h0;
      res_pass               <= 1'b0;
      res_pn                 <= 32'h0;
      seq_error              <= 1'b0;
      replay_fail_error_flag <= 1'b0;
      ctx_invalid            <= 1'b0;
    end else if (state_r == ST_IDLE && req_valid) begin
      do_wb_r                <= 1'b0;
      res_pass               <= (req_flow == FLOW_BYPASS);
      res_pn                 <= 32'h0;
      seq_error              <= 1'b0;
      replay_fail_error_flag <= 1'b0;
      ctx_invalid            <= 1'b0;
    end else if (state_r == ST_CHECK && !fetch_pend_r) begin
      if (!ctrl_ok) begin
        ctx_invalid <= 1'b1;
        res_pass    <= 1'b0;
      end else if (is_eg) begin
        if (seq_r == SEQ_MAX) begin
          seq_error <= 1'b1;
          res_pass  <= 1'b0;
        end else begin
          res_pn    <= seq_r + 32'h1;
          seq_new_r <= seq_r + 32'h1;
          do_wb_r   <= 1'b1;
          res_pass  <= 1'b1;
        end
      end else if (ig_fresh) begin
        res_pn    <= pn_r;
        seq_new_r <= pn_r + 32'h1;
        do_wb_r   <= upd_seq;
        res_pass  <= 1'b1;
      end else if (ig_window) begin
        res_pn   <= pn_r;
        res_pass <= 1'b1;
      end else begin
        replay_fail_error_flag <= 1'b1;
        res_pass               <= 1'b0;
      end
    end
  end

  // Direction and association number as seen by the transform stage.
  assign res_is_egress = is_eg;
  assign res_an        = ctrl_r[F_AN_LSB +: 2];
  assign res_aes256    = big_key;
  assign res_valid     = (state_r == ST_DONE);

  // Status register mirrors the last outcome for software.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_r <= 3'h0;
    end else if (res_valid) begin
      status_r <= {ctx_invalid, replay_fail_error_flag, seq_error};
    end
  end

  // Record storage.
  ctx_ram #(.DEPTH(DEPTH), .AW(AW)) u_ram (
    .clk_sys (clk_sys),
    .a_we    (a_we),
    .a_addr  (a_addr),
    .a_wdata (pwdata),
    .a_rdata (a_rdata),
    .b_we    (b_we),
    .b_addr  (b_addr),
    .b_wdata (seq_new_r),
    .b_rdata (b_rdata)
  );

  // Wrap never writes back.
  AST_WRAP_NO_WB: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == ST_CHECK && !fetch_pend_r && ctrl_ok && is_eg && seq_r == SEQ_MAX)
    |=> seq_error && !do_wb_r && !b_we) else $error("wrap wrote back");
  // Egress writes back stored plus one.
  AST_EG_INC: assert property (@(posedge clk_sys) disable iff (reset)
    b_we && is_eg |-> seq_new_r == $past(seq_r, 2) + 32'h1) else $error("bad egress increment");
  // Only the sequence word is written.
  AST_WB_SEQ_ONLY: assert property (@(posedge clk_sys) disable iff (reset)
    b_we |-> b_addr == AW'(sa_r * REC_WORDS_MAX + seq_word)) else $error("wrong word written");
  // Bypass and drop finish in two cycles with no memory read.
  AST_BYPASS: assert property (@(posedge clk_sys) disable iff (reset)
    (req_ready && req_valid && req_flow != FLOW_MACSEC) |=> res_valid && !fetch_pend_r)
    else $error("bypass touched record");
  // Late packet outside window raises the flag.
  AST_REPLAY: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == ST_CHECK && !fetch_pend_r && ctrl_ok && is_ig && !ig_fresh && !ig_window)
    |=> replay_fail_error_flag && !res_pass && !do_wb_r) else $error("replay not flagged");
  // In-window late packet passes without update.
  AST_WINDOW: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == ST_CHECK && !fetch_pend_r && ctrl_ok && is_ig && !ig_fresh && ig_window)
    |=> res_pass && !do_wb_r) else $error("window packet mishandled");
  // Fresh ingress writes received plus one only with update set.
  AST_IG_UPD: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == ST_CHECK && !fetch_pend_r && ctrl_ok && is_ig && ig_fresh)
    |=> do_wb_r == upd_seq && seq_new_r == pn_r + 32'h1) else $error("bad ingress update");
  // Small record fetch stops at its last word.
  AST_SIZE: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == ST_FETCH) |-> widx_r < (config_r[0] ? 5'(REC_WORDS_SMALL) : 5'(REC_WORDS_MAX)))
    else $error("fetch overran record");
  // Main scenarios.
  COV_EGRESS: cover property (@(posedge clk_sys) res_valid && res_is_egress && res_pass);
  COV_WRAP:   cover property (@(posedge clk_sys) res_valid && seq_error);
  COV_REPLAY: cover property (@(posedge clk_sys) res_valid && replay_fail_error_flag);
endmodule : ctx_seq_check

// ==== test/host_model.sv ====
// Host software model: an APB master that fills transform records and reads them back.
// Assumes the block answers every access with pready and keeps 24-word record slots.
`timescale 1ns/1ps
module host_model
  import ctx_pkg::*;
(
  input  wire logic        clk_sys,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] expv [4][24];  // Record words as software expects them, write-backs included.

  // The bus is idle from time zero, so nothing is requested during reset.
  initial begin
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // Byte address of word w of the record of SA sa.
  function automatic logic [11:0] rec_addr(input int sa, input int w);
    return 12'(A_RECORD + 4 * (sa * 24 + w));
  endfunction : rec_addr

  // One APB transfer; the request is held until pready is seen at a rising edge.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys iff pready);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Builds a MACsec control word with every mandatory bit set as required.
  function automatic logic [31:0] ctrl_word(input logic [3:0] top, input logic [2:0] ciph,
                                            input logic [1:0] an, input logic ing);
    logic [31:0] c;
    c = 32'h0;                  // Reserved bits stay zero.
    c[3:0] = top;
    c[7:5] = 3'b011;
    c[16:13] = 4'hf;
    c[19:17] = ciph;
    c[22:21] = 2'b10;
    c[25:23] = 3'b100;
    c[27:26] = ing ? 2'b00 : an;
    c[29:28] = STYP_SEQ32;
    c[31:30] = {1'b1, ing};
    return c;
  endfunction : ctrl_word

  // Writes a whole record before any packet uses it; key words get distinct patterns.
  task automatic load(input int sa, input logic [31:0] ctrl, input int sw,
                      input logic [31:0] seq, input logic [31:0] mask);
    logic [31:0] q;
    logic        e;
    for (int w = 0; w < 24; w++) begin
      expv[sa][w] = 32'(32'h0a000000 + sa * 65536 + w);
      if (w == 0) expv[sa][w] = ctrl;
      if (w == sw) expv[sa][w] = seq;
      if (w == sw + 2) expv[sa][w] = mask;
      xfer(1'b1, rec_addr(sa, w), expv[sa][w], q, e);
    end
  endtask : load
endmodule : host_model

// ==== test/tb_top.sv ====
// Self-checking bench for the record interpreter: packets in, results and records checked.
// Assumes host_model drives APB and this module drives the packet request port.
`timescale 1ns/1ps
module tb_top;
  import ctx_pkg::*;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, req_pn, res_pn;
  logic req_valid, req_ready, res_valid, res_pass, res_is_egress, res_aes256;
  logic seq_error, replay_fail_error_flag, ctx_invalid;
  logic [1:0]   req_sa, res_an;
  logic [255:0] res_key;
  logic [127:0] res_hash_key;
  flow_t        req_flow;
  int           fails, check_count;
  logic [31:0]  ipn [3] = '{32'd12, 32'd11, 32'd9};     // Received numbers, ingress case.
  logic [31:0]  ifl [3] = '{32'h28, 32'h28, 32'h0a};    // Expected flags for each.

  ctx_seq_check #(.NUM_SA(4)) uut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_ready, .req_flow, .req_sa, .req_pn,
    .res_valid, .res_pass, .res_is_egress, .res_pn, .res_an, .res_aes256, .res_key,
    .res_hash_key, .seq_error, .replay_fail_error_flag, .ctx_invalid);
  host_model host (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);

  // Free-running 200 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Result flags packed so one compare covers them all.
  function automatic logic [31:0] flags();
    return {26'h0, res_pass, res_is_egress, res_aes256, seq_error, replay_fail_error_flag,
            ctx_invalid};
  endfunction : flags

  // Counts a compare and reports a mismatch at once.
  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, ex, got);
    end
  endtask : chk

  // One packet request; waits for the take and then the result pulse.
  task automatic pkt(input flow_t f, input logic [1:0] sa, input logic [31:0] pn);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_flow  <= f;
    req_sa    <= sa;
    req_pn    <= pn;
    @(posedge clk_sys iff req_ready);
    req_valid <= 1'b0;
    @(posedge clk_sys iff res_valid);
    #1;
  endtask : pkt

  // Reads a whole record back and compares it with what software expects.
  task automatic vrec(input int sa);
    for (int w = 0; w < 24; w++) begin
      host.xfer(1'b0, host.rec_addr(sa, w), 32'h0, q, e);
      chk("record word", host.expv[sa][w], q);
    end
  endtask : vrec

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  // Watchdog: the tests need well under this many cycles.
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    finish_test();
  end

  // Main sequence.
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req_flow = FLOW_MACSEC;
    req_sa = 2'h0;
    req_pn = 32'h0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    host.xfer(1'b0, A_CONFIG, 32'h0, q, e);
    chk("config reset", CONFIG_RST, q);
    host.xfer(1'b0, 12'h100, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    // Egress, 128-bit key, association number 2, stored sequence 5.
    host.load(0, host.ctrl_word(TOP_EGRESS, CIPH_AES128, 2'h2, 1'b0), W_SEQ128, 32'h5, 32'h0);
    pkt(FLOW_MACSEC, 2'h0, 32'h0);
    chk("egress flags", 32'h30, flags());
    chk("egress pn", 32'h6, res_pn);
    chk("egress an", 32'h2, {30'h0, res_an});
    chk("key word 0", host.expv[0][W_KEY0], res_key[31:0]);
    chk("key word 3", host.expv[0][W_KEY0 + 3], res_key[127:96]);
    chk("hash word 0", host.expv[0][W_HK128], res_hash_key[31:0]);
    host.expv[0][W_SEQ128] = 32'h6;
    vrec(0);
    // Flows that bypass or drop leave the record alone.
    pkt(FLOW_BYPASS, 2'h0, 32'h0);
    pkt(FLOW_DROP, 2'h0, 32'h0);
    vrec(0);
    // Egress wrap: errors on every try and never updates.
    host.load(3, host.ctrl_word(TOP_EGRESS, CIPH_AES128, 2'h0, 1'b0), W_SEQ128, SEQ_MAX, 32'h0);
    for (int i = 0; i < 2; i++) begin
      pkt(FLOW_MACSEC, 2'h3, 32'h0);
      chk("wrap flags", 32'h14, flags());
    end
    vrec(3);
    // Ingress, 256-bit key, next number 10, window 3.
    host.load(1, host.ctrl_word(TOP_INGRESS, CIPH_AES256, 2'h0, 1'b1), W_SEQ256, 32'd10, 32'd3);
    host.expv[1][W_SEQ256] = 32'd13;
    for (int i = 0; i < 3; i++) begin
      pkt(FLOW_MACSEC, 2'h1, ipn[i]);
      chk("ingress flags", ifl[i], flags());
      host.xfer(1'b0, host.rec_addr(1, W_SEQ256), 32'h0, q, e);
      chk("ingress next", 32'd13, q);
    end
    host.xfer(1'b0, A_STATUS, 32'h0, q, e);
    chk("status replay", 32'h2, q);
    chk("key word 7", host.expv[1][W_KEY0 + 7], res_key[255:224]);
    chk("hash word 3", host.expv[1][W_HK256 + 3], res_hash_key[127:96]);
    // Small fetch size still reaches the ingress sequence word.
    host.xfer(1'b1, A_CONFIG, 32'h1, q, e);
    host.xfer(1'b0, A_CONFIG, 32'h0, q, e);
    chk("config size", 32'h1, q);
    pkt(FLOW_MACSEC, 2'h1, 32'd13);
    chk("small flags", 32'h28, flags());
    host.expv[1][W_SEQ256] = 32'd14;
    vrec(1);
    host.xfer(1'b1, A_CONFIG, 32'h0, q, e);
    // Invalid packet type is refused and nothing is written back.
    host.load(2, host.ctrl_word(4'h3, CIPH_AES128, 2'h0, 1'b0), W_SEQ128, 32'h0, 32'h0);
    pkt(FLOW_MACSEC, 2'h2, 32'h0);
    chk("invalid flags", 32'h1, {30'h0, res_pass, ctx_invalid});
    host.xfer(1'b0, A_STATUS, 32'h0, q, e);
    chk("status invalid", 32'h4, q);
    vrec(2);
    finish_test();
  end
endmodule : tb_top
